// >>> core/fault_prot_pkg.sv
// Shared types, constants and decoders for the motor fault protection block
package fault_prot_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;

    // Comparator deglitch times in microseconds, by select code
    localparam int unsigned DEGL_US_0 = 1;
    localparam int unsigned DEGL_US_1 = 2;
    localparam int unsigned DEGL_US_2 = 5;
    localparam int unsigned DEGL_US_3 = 10;
    localparam logic [8:0] DEGL_CYC_0 = 9'(DEGL_US_0 * CLK_HZ / 1_000_000);
    localparam logic [8:0] DEGL_CYC_1 = 9'(DEGL_US_1 * CLK_HZ / 1_000_000);
    localparam logic [8:0] DEGL_CYC_2 = 9'(DEGL_US_2 * CLK_HZ / 1_000_000);
    localparam logic [8:0] DEGL_CYC_3 = 9'(DEGL_US_3 * CLK_HZ / 1_000_000);

    // Lock retry times in milliseconds, by select code
    localparam int unsigned RETRY_MS_0 = 100;
    localparam int unsigned RETRY_MS_1 = 500;
    localparam int unsigned RETRY_MS_2 = 1000;
    localparam int unsigned RETRY_MS_3 = 5000;

    localparam int unsigned SPEED_W = 16;

    // Action field layout and fixed codes
    localparam logic [3:0] ACT_REPORT_CODE = 4'h8;
    localparam int unsigned ACT_MSB = 3;

    typedef enum logic [1:0] {
        ACT_LATCH, ACT_RETRY, ACT_REPORT, ACT_OFF
    } action_e;

    typedef enum logic [2:0] {
        SW_NORMAL, SW_ALL_OFF, SW_RECIRC_OFF, SW_HIGH_ON, SW_LOW_ON, SW_HIZ
    } sw_state_e;

    typedef struct packed {
        logic controller_fault;
        logic driver_fault;
        logic current_limit_lock;
        logic motor_lock;
        logic abnormal_speed_lock;
        logic bemf_lock;
        logic no_motor_lock;
        logic over_temp_flag;
        logic temp_warning;
        logic temp_shutdown_flag;
    } status_s;

    // Unlisted 1xxx codes are treated as disabled
    function automatic action_e decode_action(input logic [3:0] code);
        if (!code[ACT_MSB])
            return code[2] ? ACT_RETRY : ACT_LATCH;
        else if (code == ACT_REPORT_CODE)
            return ACT_REPORT;
        else
            return ACT_OFF;
    endfunction : decode_action

    function automatic sw_state_e decode_switch(input logic [3:0] code);
        case (code[1:0])
            2'h0:    return SW_ALL_OFF;
            2'h1:    return SW_RECIRC_OFF;
            2'h2:    return SW_HIGH_ON;
            default: return SW_LOW_ON;
        endcase
    endfunction : decode_switch
endpackage : fault_prot_pkg

// >>> core/fault_responder.sv
// Per-source fault response: latched, auto-retry, report-only or disabled
`timescale 1ns/1ps
module fault_responder (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  cond_in,
    input  wire logic [3:0]            action_in,
    input  wire logic                  clear_in,
    input  wire logic [31:0]           retry_cyc_in,
    output logic                       enter_out,
    output logic                       flag_out,
    output logic                       pin_low_out,
    output logic                       protect_out,
    output fault_prot_pkg::sw_state_e  switch_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_RETRY, ST_REPORT} resp_state_e;

    resp_state_e               state_r;
    resp_state_e               state_nxt;
    fault_prot_pkg::sw_state_e sw_r;
    logic [31:0]               cnt_r;
    fault_prot_pkg::action_e   act;
    logic                      retry_done;
    logic                      clr_ok;

    assign act        = fault_prot_pkg::decode_action(action_in);
    // Disabled mode never leaves idle
    assign enter_out  = (state_r == ST_IDLE) && cond_in
                        && (act != fault_prot_pkg::ACT_OFF);
    assign retry_done = (cnt_r >= retry_cyc_in - 32'h1);
    // Clear only acts once the condition is gone
    assign clr_ok     = clear_in && !cond_in;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (enter_out) begin
                    case (act)
                        fault_prot_pkg::ACT_LATCH: state_nxt = ST_LATCH;
                        fault_prot_pkg::ACT_RETRY: state_nxt = ST_RETRY;
                        default:                   state_nxt = ST_REPORT;
                    endcase
                end
            end
            ST_LATCH:  if (clr_ok) state_nxt = ST_IDLE;
            ST_RETRY:  if (retry_done) state_nxt = ST_IDLE;
            ST_REPORT: if (clr_ok) state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            sw_r    <= fault_prot_pkg::SW_ALL_OFF;
            cnt_r   <= 32'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_r == ST_RETRY) ? cnt_r + 32'h1 : 32'h0;
            if (enter_out)
                sw_r <= fault_prot_pkg::decode_switch(action_in);
        end
    end

    // Status stays up in every active mode
    assign flag_out    = (state_r != ST_IDLE);
    assign protect_out = (state_r == ST_LATCH) || (state_r == ST_RETRY);
    assign pin_low_out = protect_out;
    assign switch_out  = sw_r;

    AST_RETRY_EXPIRY: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (state_r == ST_RETRY) && retry_done |=> !flag_out)
        else $error("Retry expiry did not clear the fault flag");
endmodule : fault_responder

// >>> core/motor_fault_protection.sv
// Fault response controller for current-limit lock, thermal and motor lock
`timescale 1ns/1ps
// Behaviour
// - Comparator must stay high beyond deglitch time
// - Current-limit action: latch, retry, report, disabled
// - Motor-lock action uses the same encoding
// - Low two bits choose switch state
// - Latch/retry: pin low, summary and source bits
// - Latched clears on clear command, condition gone
// - Auto-retry resumes after lock retry time
// - Retry expiry zeroes controller and source bits
// - Report-only sets bits, drivers keep running
// - Report-only clears on clear, condition gone
// - Disabled mode does nothing at all
// - Enabled warning: pin low, bits set, running
// - Pin follows warning; bit needs clear
// - Shutdown: switches off, pump off, pin, bits
// - Auto resume; shutdown bit latched until clear
// - Thermal shutdown can never be disabled
// - Any enabled lock condition raises motor lock
// - Lock sets controller, lock and cause bits
// - Separate lock enables, one shared retry time
// - Speed above threshold raises speed lock
module motor_fault_protection #(
    parameter int unsigned RETRY_CYC_0 = fault_prot_pkg::RETRY_MS_0
                                         * (fault_prot_pkg::CLK_HZ / 1000),
    parameter int unsigned RETRY_CYC_1 = fault_prot_pkg::RETRY_MS_1
                                         * (fault_prot_pkg::CLK_HZ / 1000),
    parameter int unsigned RETRY_CYC_2 = fault_prot_pkg::RETRY_MS_2
                                         * (fault_prot_pkg::CLK_HZ / 1000),
    parameter int unsigned RETRY_CYC_3 = fault_prot_pkg::RETRY_MS_3
                                         * (fault_prot_pkg::CLK_HZ / 1000)
) (
    input  wire logic                       clk_in,
    input  wire logic                       resetn_in,
    input  wire logic                       current_sense_amp_cmp_in,
    input  wire logic [1:0]                 current_limit_deglitch_in,
    input  wire logic [3:0]                 current_limit_lock_action_in,
    input  wire logic [3:0]                 motor_lock_action_in,
    input  wire logic [1:0]                 lock_retry_time_in,
    input  wire logic                       temp_warning_in,
    input  wire logic                       temp_warning_report_en_in,
    input  wire logic                       thermal_shutdown_in,
    input  wire logic [15:0]                speed_estimate_in,
    input  wire logic [15:0]                abnormal_speed_threshold_in,
    input  wire logic                       speed_lock_en_in,
    input  wire logic                       bemf_lock_en_in,
    input  wire logic                       no_motor_lock_en_in,
    input  wire logic                       bemf_lock_cond_in,
    input  wire logic                       no_motor_cond_in,
    input  wire logic                       clear_fault_cmd_in,
    output logic                            fault_pin_n_out,
    output logic                            fault_pin_n_oe_out,
    output logic                            charge_pump_en_out,
    output fault_prot_pkg::sw_state_e       switch_state_out,
    output fault_prot_pkg::status_s         status_out
);
    // Deglitch and speed detection
    logic [8:0]  degl_cnt_r;
    logic [8:0]  degl_lim;
    logic        cl_cond;
    logic        speed_cond_r;
    logic        ml_cond;
    logic [2:0]  lock_conds;
    logic [31:0] retry_cyc;

    // Responder outputs
    logic                      cl_enter;
    logic                      cl_flag;
    logic                      cl_pin;
    logic                      cl_protect;
    fault_prot_pkg::sw_state_e cl_sw;
    logic                      ml_enter;
    logic                      ml_flag;
    logic                      ml_pin;
    logic                      ml_protect;
    fault_prot_pkg::sw_state_e ml_sw;

    // Sticky and output state
    logic [2:0]                lock_bits_r;
    logic [2:0]                lock_bits_nxt;
    logic                      warn_r;
    logic                      ots_r;
    logic                      ot_r;
    logic                      drv_fault_r;
    logic                      pin_low_r;
    logic                      pin_low_nxt;
    logic                      cp_en_r;
    fault_prot_pkg::sw_state_e sw_r;
    fault_prot_pkg::sw_state_e sw_nxt;
    logic                      warn_evt;

    assign degl_lim = (current_limit_deglitch_in == 2'h0) ? fault_prot_pkg::DEGL_CYC_0 :
                      (current_limit_deglitch_in == 2'h1) ? fault_prot_pkg::DEGL_CYC_1 :
                      (current_limit_deglitch_in == 2'h2) ? fault_prot_pkg::DEGL_CYC_2 :
                                                            fault_prot_pkg::DEGL_CYC_3;

    // One retry time shared by both lock sources
    assign retry_cyc = (lock_retry_time_in == 2'h0) ? 32'(RETRY_CYC_0) :
                       (lock_retry_time_in == 2'h1) ? 32'(RETRY_CYC_1) :
                       (lock_retry_time_in == 2'h2) ? 32'(RETRY_CYC_2) :
                                                      32'(RETRY_CYC_3);

    // Event only once high for longer than the deglitch time
    assign cl_cond = (degl_cnt_r > degl_lim);

    always_ff @(posedge clk_in) begin
        if (!resetn_in)
            degl_cnt_r <= 9'h0;
        else if (!current_sense_amp_cmp_in)
            degl_cnt_r <= 9'h0;
        else if (degl_cnt_r <= degl_lim)
            degl_cnt_r <= degl_cnt_r + 9'h1;
    end

    // Speed compare runs continuously while enabled
    always_ff @(posedge clk_in) begin
        if (!resetn_in)
            speed_cond_r <= 1'b0;
        else
            speed_cond_r <= speed_lock_en_in
                            && (speed_estimate_in > abnormal_speed_threshold_in);
    end

    // Each detector has its own enable
    assign lock_conds = {speed_cond_r,
                         bemf_lock_en_in && bemf_lock_cond_in,
                         no_motor_lock_en_in && no_motor_cond_in};
    assign ml_cond    = |lock_conds;

    // Current-limit lock response
    fault_responder u_cl_resp (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .cond_in      (cl_cond),
        .action_in    (current_limit_lock_action_in),
        .clear_in     (clear_fault_cmd_in),
        .retry_cyc_in (retry_cyc),
        .enter_out    (cl_enter),
        .flag_out     (cl_flag),
        .pin_low_out  (cl_pin),
        .protect_out  (cl_protect),
        .switch_out   (cl_sw)
    );

    // Motor lock response, same encoding
    fault_responder u_ml_resp (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .cond_in      (ml_cond),
        .action_in    (motor_lock_action_in),
        .clear_in     (clear_fault_cmd_in),
        .retry_cyc_in (retry_cyc),
        .enter_out    (ml_enter),
        .flag_out     (ml_flag),
        .pin_low_out  (ml_pin),
        .protect_out  (ml_protect),
        .switch_out   (ml_sw)
    );

    // Cause bits caught at entry, kept while the lock fault stands
    assign lock_bits_nxt = ml_enter ? lock_conds :
                           ml_flag  ? (lock_bits_r | lock_conds) : 3'h0;

    assign warn_evt = temp_warning_in && temp_warning_report_en_in;

    // Shutdown is unconditional; no enable exists for it
    assign pin_low_nxt = cl_pin || ml_pin || warn_evt
                         || thermal_shutdown_in;

    // Shutdown outranks the lock switch patterns
    assign sw_nxt = thermal_shutdown_in ? fault_prot_pkg::SW_HIZ :
                    cl_protect          ? cl_sw :
                    ml_protect          ? ml_sw :
                                          fault_prot_pkg::SW_NORMAL;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            lock_bits_r <= 3'h0;
            pin_low_r   <= 1'b0;
            sw_r        <= fault_prot_pkg::SW_NORMAL;
            cp_en_r     <= 1'b1;
            drv_fault_r <= 1'b0;
        end else begin
            lock_bits_r <= lock_bits_nxt;
            pin_low_r   <= pin_low_nxt;
            sw_r        <= sw_nxt;
            cp_en_r     <= !thermal_shutdown_in;
            drv_fault_r <= thermal_shutdown_in;
        end
    end

    // Sticky thermal bits: a new event outranks a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            warn_r <= 1'b0;
            ots_r  <= 1'b0;
            ot_r   <= 1'b0;
        end else begin
            if (warn_evt)
                warn_r <= 1'b1;
            else if (clear_fault_cmd_in && !temp_warning_in)
                warn_r <= 1'b0;
            if (thermal_shutdown_in)
                ots_r <= 1'b1;
            else if (clear_fault_cmd_in)
                ots_r <= 1'b0;
            if (warn_evt || thermal_shutdown_in)
                ot_r <= 1'b1;
            else if (clear_fault_cmd_in && !temp_warning_in)
                ot_r <= 1'b0;
        end
    end

    // Open-drain pin: only ever pulled low
    assign fault_pin_n_out    = 1'b0;
    assign fault_pin_n_oe_out = pin_low_r;
    assign charge_pump_en_out = cp_en_r;
    assign switch_state_out   = sw_r;

    always_comb begin
        status_out                     = '0;
        status_out.controller_fault    = cl_flag || ml_flag;
        status_out.driver_fault        = drv_fault_r;
        status_out.current_limit_lock  = cl_flag;
        status_out.motor_lock          = ml_flag;
        status_out.abnormal_speed_lock = lock_bits_r[2];
        status_out.bemf_lock           = lock_bits_r[1];
        status_out.no_motor_lock       = lock_bits_r[0];
        status_out.over_temp_flag      = ot_r;
        status_out.temp_warning        = warn_r;
        status_out.temp_shutdown_flag  = ots_r;
    end

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    logic cl_act_off;
    logic ml_act_off;
    logic cl_act_latch;
    logic cl_act_retry;
    logic cl_act_report;
    assign cl_act_off    = fault_prot_pkg::decode_action(current_limit_lock_action_in)
                           == fault_prot_pkg::ACT_OFF;
    assign ml_act_off    = fault_prot_pkg::decode_action(motor_lock_action_in)
                           == fault_prot_pkg::ACT_OFF;
    assign cl_act_latch  = fault_prot_pkg::decode_action(current_limit_lock_action_in)
                           == fault_prot_pkg::ACT_LATCH;
    assign cl_act_retry  = fault_prot_pkg::decode_action(current_limit_lock_action_in)
                           == fault_prot_pkg::ACT_RETRY;
    assign cl_act_report = fault_prot_pkg::decode_action(current_limit_lock_action_in)
                           == fault_prot_pkg::ACT_REPORT;

    // Latched entry remembered, so a later field change cannot mask a release
    logic cl_latched_r;
    always_ff @(posedge clk_in) begin
        if (!resetn_in)
            cl_latched_r <= 1'b0;
        else if (cl_enter)
            cl_latched_r <= cl_act_latch;
        else if (!cl_flag)
            cl_latched_r <= 1'b0;
    end

    sequence s_cl_latched;
        cl_enter && cl_act_latch;
    endsequence

    // Status bits land one edge before the registered pin
    sequence s_pin_and_bits;
        status_out.controller_fault && status_out.current_limit_lock
        ##1 fault_pin_n_oe_out;
    endsequence

    AST_DEGLITCH_LOW: assert property (
        !current_sense_amp_cmp_in |=> !cl_cond ##1 !cl_enter)
        else $error("Current-limit event without sustained comparator");

    AST_LATCH_PIN_BITS: assert property (
        s_cl_latched |=> s_pin_and_bits)
        else $error("Latched event missing pin or status bits");

    AST_LATCH_HOLDS: assert property (
        cl_latched_r && cl_flag && cl_cond |=> cl_flag)
        else $error("Latched fault released while condition active");

    AST_CL_SWITCH: assert property (
        cl_enter && (cl_act_latch || cl_act_retry) && !thermal_shutdown_in
        ##1 !thermal_shutdown_in
        |=> switch_state_out
            == fault_prot_pkg::decode_switch($past(current_limit_lock_action_in, 2)))
        else $error("Switch state does not follow action low bits");

    AST_REPORT_RUNS: assert property (
        cl_enter && cl_act_report |=> cl_flag && !cl_protect)
        else $error("Report-only mode took protective action");

    AST_DISABLED_QUIET: assert property (
        ml_act_off && !ml_flag |=> !ml_flag && !ml_pin)
        else $error("Disabled motor lock mode reacted");

    AST_CL_DISABLED: assert property (
        cl_act_off && !cl_flag |=> !cl_flag)
        else $error("Disabled current-limit mode reacted");

    AST_WARN_PIN: assert property (
        warn_evt |=> fault_pin_n_oe_out && status_out.temp_warning
                     && status_out.over_temp_flag)
        else $error("Enabled warning did not pull pin and set bits");

    AST_WARN_STICKY: assert property (
        status_out.temp_warning && !clear_fault_cmd_in |=> status_out.temp_warning)
        else $error("Warning bit dropped without clear");

    AST_TSD_ACTION: assert property (
        thermal_shutdown_in |=> switch_state_out == fault_prot_pkg::SW_HIZ
                                && !charge_pump_en_out && fault_pin_n_oe_out
                                && status_out.driver_fault && status_out.temp_shutdown_flag)
        else $error("Thermal shutdown response incomplete");

    AST_TSD_STICKY: assert property (
        status_out.temp_shutdown_flag && !clear_fault_cmd_in
        |=> status_out.temp_shutdown_flag)
        else $error("Shutdown bit cleared without clear command");

    AST_TSD_RESUME: assert property (
        !thermal_shutdown_in [*2] |-> charge_pump_en_out)
        else $error("Charge pump not restored after shutdown");

    AST_SPEED_LOCK: assert property (
        speed_lock_en_in && (speed_estimate_in > abnormal_speed_threshold_in)
        && !ml_act_off && !ml_flag
        |=> ##1 ml_flag ##1 status_out.abnormal_speed_lock)
        else $error("Abnormal speed did not raise motor lock");

    AST_RETRY_PIN_BITS: assert property (
        cl_enter && cl_act_retry |=> s_pin_and_bits)
        else $error("Retry event missing pin or status bits");

    AST_ML_BITS: assert property (
        ml_enter |=> status_out.controller_fault && status_out.motor_lock
                     && (status_out.abnormal_speed_lock || status_out.bemf_lock
                         || status_out.no_motor_lock))
        else $error("Motor lock entry missing summary or cause bits");

    AST_PIN_RELEASE: assert property (
        !temp_warning_in && !thermal_shutdown_in && !cl_pin && !ml_pin
        |=> !fault_pin_n_oe_out)
        else $error("Fault pin held low with no source active");
endmodule : motor_fault_protection

// >>> sim/host_model.sv
// Host side model: fault line pull-up and clear-fault writes
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_in,
    input  wire logic pin_n_in,
    input  wire logic pin_oe_in,
    output logic      clear_out,
    output logic      line_out
);
    // Released open-drain line reads high through the pull-up
    assign line_out = pin_oe_in ? pin_n_in : 1'b1;
    initial clear_out = 1'b0;
    // One-cycle write of one to the clear bit
    task automatic send_clear();
        @(posedge clk_in);
        clear_out <= 1'b1;
        @(posedge clk_in);
        clear_out <= 1'b0;
    endtask : send_clear
endmodule : host_model

// >>> sim/tb_top.sv
// Self-checking bench for the motor fault protection block
`timescale 1ns/1ps
module tb_top;
    logic        clk_in = 0, resetn_in = 0, cmp = 0, tw = 0, tw_en = 0, thermal_shutdown = 0;
    logic        sl_en = 0, bl_en = 0, nm_en = 0, bl = 0, nm = 0;
    logic        clr, pin_n, pin_oe, pump, line;
    logic [1:0]  rsel = 0, dsel = 0;
    logic [3:0]  cl_act = 0, ml_act = 0;
    logic [15:0] spd = 0, thr = 16'hffff;
    fault_prot_pkg::sw_state_e sw;
    fault_prot_pkg::status_s   st;
    int          err_total = 0, total_checks = 0, cycles = 0, k, r;
    int          degl [4] = '{fault_prot_pkg::DEGL_CYC_0, fault_prot_pkg::DEGL_CYC_1,
                              fault_prot_pkg::DEGL_CYC_2, fault_prot_pkg::DEGL_CYC_3};

    always #12.5 clk_in = ~clk_in;

    // Short retry counts keep the run brief
    motor_fault_protection #(.RETRY_CYC_0(20), .RETRY_CYC_1(40), .RETRY_CYC_2(60),
        .RETRY_CYC_3(80)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
        .current_sense_amp_cmp_in(cmp), .current_limit_deglitch_in(dsel),
        .current_limit_lock_action_in(cl_act), .motor_lock_action_in(ml_act),
        .lock_retry_time_in(rsel), .temp_warning_in(tw), .temp_warning_report_en_in(tw_en),
        .thermal_shutdown_in(thermal_shutdown), .speed_estimate_in(spd), .abnormal_speed_threshold_in(thr),
        .speed_lock_en_in(sl_en), .bemf_lock_en_in(bl_en), .no_motor_lock_en_in(nm_en),
        .bemf_lock_cond_in(bl), .no_motor_cond_in(nm), .clear_fault_cmd_in(clr),
        .fault_pin_n_out(pin_n), .fault_pin_n_oe_out(pin_oe), .charge_pump_en_out(pump),
        .switch_state_out(sw), .status_out(st));
    host_model host (.clk_in(clk_in), .pin_n_in(pin_n), .pin_oe_in(pin_oe),
        .clear_out(clr), .line_out(line));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc

    // Expected switch state for the low two action bits
    function automatic fault_prot_pkg::sw_state_e exp_sw(input int c);
        case (c % 4)
            0:       return fault_prot_pkg::SW_ALL_OFF;
            1:       return fault_prot_pkg::SW_RECIRC_OFF;
            2:       return fault_prot_pkg::SW_HIGH_ON;
            default: return fault_prot_pkg::SW_LOW_ON;
        endcase
    endfunction : exp_sw

    // Pump is expected off only in the high-impedance state
    task automatic chk(input logic [9:0] e_st, input logic e_low,
        input fault_prot_pkg::sw_state_e e_sw = fault_prot_pkg::SW_NORMAL);
        @(negedge clk_in);
        total_checks++;
        if (st !== e_st || line !== !e_low || sw !== e_sw
            || pump !== (e_sw != fault_prot_pkg::SW_HIZ)) begin
            err_total++;
            $display("wrong value t=%0t st=%b line=%b sw=%0d", $time, st, line, sw);
        end
        @(posedge clk_in);
    endtask : chk

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // Hang guard, well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        r = $urandom(32'h8aad);
        cyc(6);
        resetn_in <= 1'b1;
        cyc(2);
        chk(10'h000, 0);
        for (k = 0; k < 4; k++) begin
            cl_act <= k[3:0];
            dsel <= k[1:0];
            cmp <= 1'b1;
            cyc(degl[k]);
            cmp <= 1'b0;
            cyc(4);
            chk(10'h000, 0);
            cmp <= 1'b1;
            cyc(degl[k] + 1);
            chk(10'h000, 0);
            cyc(1);
            chk(10'h280, 1, exp_sw(k));
            host.send_clear();
            cyc(3);
            chk(10'h280, 1, exp_sw(k));
            cmp <= 1'b0;
            cyc(4);
            chk(10'h280, 1, exp_sw(k));
            host.send_clear();
            cyc(3);
            chk(10'h000, 0);
        end
        $display("test latched done");
        dsel <= 2'h0;
        for (k = 0; k < 3; k++) begin
            r = $urandom;
            cl_act <= {2'b01, r[1:0]};
            rsel <= r[3:2];
            cmp <= 1'b1;
            cyc(50);
            cmp <= 1'b0;
            chk(10'h280, 1, exp_sw(r[1:0]));
            cyc(20 * (r[3:2] + 1) - 10);
            chk(10'h280, 1, exp_sw(r[1:0]));
            cyc(1);
            chk(10'h000, 0);
        end
        $display("test retry done");
        cl_act <= 4'h8;
        cmp <= 1'b1;
        cyc(50);
        chk(10'h280, 0);
        cmp <= 1'b0;
        cyc(4);
        chk(10'h280, 0);
        host.send_clear();
        cyc(3);
        chk(10'h000, 0);
        for (k = 9; k < 16; k += 2) begin
            cl_act <= k[3:0];
            cmp <= 1'b1;
            cyc(50);
            cmp <= 1'b0;
            chk(10'h000, 0);
        end
        $display("test report and disabled done");
        r = $urandom;
        thr <= {1'b0, r[14:0]};
        spd <= {1'b0, r[14:0]};
        ml_act <= {2'b00, r[17:16]};
        sl_en <= 1'b1;
        cyc(6);
        chk(10'h000, 0);
        spd <= 16'(r[14:0] + 1);
        cyc(6);
        chk(10'h260, 1, exp_sw(r[17:16]));
        spd <= 16'h0000;
        cyc(4);
        host.send_clear();
        cyc(3);
        chk(10'h000, 0);
        sl_en <= 1'b0;
        spd <= 16'hffff;
        ml_act <= 4'h5;
        rsel <= 2'h0;
        bl_en <= 1'b1;
        nm <= 1'b1;
        bl <= 1'b1;
        cyc(3);
        bl <= 1'b0;
        chk(10'h250, 1, fault_prot_pkg::SW_RECIRC_OFF);
        cyc(30);
        chk(10'h000, 0);
        nm <= 1'b0;
        ml_act <= 4'h8;
        bl <= 1'b1;
        cyc(3);
        bl <= 1'b0;
        chk(10'h250, 0);
        cyc(2);
        chk(10'h250, 0);
        host.send_clear();
        cyc(3);
        chk(10'h000, 0);
        ml_act <= 4'h9;
        bl <= 1'b1;
        cyc(3);
        chk(10'h000, 0);
        bl <= 1'b0;
        $display("test motor lock done");
        tw_en <= 1'b1;
        tw <= 1'b1;
        cyc(3);
        chk(10'h006, 1);
        tw <= 1'b0;
        cyc(3);
        chk(10'h006, 0);
        host.send_clear();
        cyc(3);
        chk(10'h000, 0);
        tw_en <= 1'b0;
        tw <= 1'b1;
        cyc(3);
        chk(10'h000, 0);
        tw <= 1'b0;
        thermal_shutdown <= 1'b1;
        cyc(3);
        chk(10'h105, 1, fault_prot_pkg::SW_HIZ);
        thermal_shutdown <= 1'b0;
        cyc(3);
        chk(10'h005, 0);
        host.send_clear();
        cyc(3);
        chk(10'h000, 0);
        $display("test thermal done");
        test_done();
    end
endmodule : tb_top
